// ===== logic/mdu_defs.vh
// constants of the multiply/divide unit
`ifndef MDU_DEFS_VH
`define MDU_DEFS_VH

// ************************************************************
// operation codes on the issue port
// ************************************************************
`define MDU_OP_PAIR_PRODUCT   3'h0
`define MDU_OP_ACCUM_ADD      3'h1
`define MDU_OP_ACCUM_SUB      3'h2
`define MDU_OP_GPR_PRODUCT    3'h3
`define MDU_OP_QUOTIENT       3'h4
`define MDU_OP_MOVE_UPPER     3'h5
`define MDU_OP_MOVE_BOTTOM    3'h6

// ************************************************************
// divider timing, in clocks
// ************************************************************
`define MDU_DIV_FULL_ITER     6'h20
`define MDU_DIV_SKIP_8        5'h17
`define MDU_DIV_SKIP_16       5'h0f
`define MDU_DIV_SKIP_24       5'h07
`define MDU_DIV_SKIP_32       5'h00
`define MDU_DIV_LAT_8         6'h0c
`define MDU_DIV_LAT_16        6'h13
`define MDU_DIV_LAT_24        6'h1a
`define MDU_DIV_LAT_32        6'h21

// ************************************************************
// divider states
// ************************************************************
`define MDU_DV_IDLE           2'h0
`define MDU_DV_SETUP          2'h1
`define MDU_DV_ITER           2'h2

// ************************************************************
// reset values
// ************************************************************
`define MDU_RST_WORD          32'h0000_0000
`define MDU_RST_DEST          5'h00

`endif

// ===== logic/mdu_booth_pass.v
// one pass of the 33x17 radix-4 booth recoded multiplier
`timescale 1ns/1ns
module mdu_booth_pass (
   input  wire [32:0] multiplicand,
   input  wire [16:0] multiplier,
   output reg  [49:0] product
);

   reg [18:0] recode;
   reg [49:0] ext_a;
   reg [49:0] part;
   integer    i;

   // ************************************************************
   // booth digits, summed with their weights
   // ************************************************************
   always @* begin
      recode  = {multiplier[16], multiplier, 1'b0};
      ext_a   = {{17{multiplicand[32]}}, multiplicand};
      part    = 50'h0;
      product = 50'h0;
      for (i = 0; i < 9; i = i + 1) begin
         case (recode[2*i+2 -: 3])
            3'h1, 3'h2: part = ext_a;
            3'h3:       part = ext_a << 1;
            3'h4:       part = 50'h0 - (ext_a << 1);
            3'h5, 3'h6: part = 50'h0 - ext_a;
            default:    part = 50'h0;
         endcase
         product = product + (part << (2 * i));
      end
   end

endmodule

// ===== logic/mdu_multiply_divide_unit.v
// multiply/divide unit beside the integer pipeline
// Overview of operation
// - runs its own pipeline; never halts when the integer pipeline stalls
// - booth 32x16 multiplier, upper/bottom result pair, iterative divide machine
// - right operand alone picks one pass (16-bit) or two passes (32-bit)
// - short multiply every clock; full multiply every other clock, interlocked
// - divide yields one quotient bit per clock
// - dividend sign extension skips 23, 15 or 7 iterations
// - any issue during an active divide is stalled until one clock before it ends
// - pair ops: latency/repeat 1/1 short, 2/2 full
// - register-file multiply: latency/repeat 2/1 short, 3/2 full
// - divide latency 12/19/26/33, repeat one clock less
// - pair-op and divide results land in the pair; move ops copy either half out
// - register-file multiply sends low product word to the register file
// - accumulate ops add to or subtract from the pair contents
`timescale 1ns/1ns
`include "mdu_defs.vh"
module mdu_multiply_divide_unit (
   input  wire        CLOCK,
   input  wire        SRST,
   input  wire        ISSUE_VALID,
   input  wire [2:0]  ISSUE_OP,
   input  wire        ISSUE_SIGNED,
   input  wire [4:0]  ISSUE_DEST,
   input  wire [31:0] LEFT_OPERAND,
   input  wire [31:0] RIGHT_OPERAND,
   output wire        STALL,
   output wire        MOVE_VALID,
   output wire [31:0] MOVE_DATA,
   output wire        GPR_WRITE_VALID,
   output wire [4:0]  GPR_WRITE_DEST,
   output wire [31:0] GPR_WRITE_DATA
);

   // ************************************************************
   // state
   // ************************************************************
   reg         stall_ff;
   reg         st_valid_ff;
   reg  [2:0]  st_op_ff;
   reg         st_sgn_ff;
   reg         st_wide_ff;
   reg  [31:0] st_a_ff;
   reg  [31:0] st_b_ff;
   reg  [4:0]  st_dest_ff;
   reg         p2_valid_ff;
   reg  [2:0]  p2_op_ff;
   reg  [4:0]  p2_dest_ff;
   reg  [32:0] p2_a_ff;
   reg  [16:0] p2_chunk_ff;
   reg  [63:0] p2_low_ff;
   reg  [31:0] upper_result_reg_ff;
   reg  [31:0] bottom_result_reg_ff;
   reg  [1:0]  dv_state_ff;
   reg  [5:0]  dv_cnt_ff;
   reg  [5:0]  dv_iter_ff;
   reg  [31:0] dv_rem_ff;
   reg  [31:0] dv_q_ff;
   reg  [31:0] dv_d_ff;
   reg         dv_negq_ff;
   reg         dv_negr_ff;
   reg  [31:0] dvr_hi_ff;
   reg  [31:0] dvr_lo_ff;
   reg         div_wb_ff;
   reg         gpr_pend_ff;
   reg  [4:0]  gpr_pdest_ff;
   reg  [31:0] gpr_pdata_ff;
   reg         gpr_valid_ff;
   reg  [4:0]  gpr_dest_ff;
   reg  [31:0] gpr_data_ff;
   reg         mv_pend_ff;
   reg         mv_sel_ff;
   reg         move_valid_ff;
   reg  [31:0] move_data_ff;

   assign STALL           = stall_ff;
   assign MOVE_VALID      = move_valid_ff;
   assign MOVE_DATA       = move_data_ff;
   assign GPR_WRITE_VALID = gpr_valid_ff;
   assign GPR_WRITE_DEST  = gpr_dest_ff;
   assign GPR_WRITE_DATA  = gpr_data_ff;

   // ************************************************************
   // issue decode
   // ************************************************************
   wire take     = ISSUE_VALID & ~stall_ff;
   wire take_mul = take & (ISSUE_OP <= `MDU_OP_GPR_PRODUCT);
   wire take_div = take & (ISSUE_OP == `MDU_OP_QUOTIENT);
   wire take_mv  = take & ((ISSUE_OP == `MDU_OP_MOVE_UPPER) | (ISSUE_OP == `MDU_OP_MOVE_BOTTOM));
   wire r_short  = ISSUE_SIGNED ? ((&RIGHT_OPERAND[31:15]) | ~(|RIGHT_OPERAND[31:15]))
                                : ~(|RIGHT_OPERAND[31:16]);
   wire r_wide   = ~r_short;

   // ************************************************************
   // multiplier passes
   // ************************************************************
   reg  [32:0] mc;
   reg  [16:0] mr;
   wire [49:0] pass_prod;
   wire [32:0] st_a_ext = {st_sgn_ff & st_a_ff[31], st_a_ff};
   wire [63:0] pass_ext = {{14{pass_prod[49]}}, pass_prod};

   always @* begin
      if (p2_valid_ff) begin
         mc = p2_a_ff;
         mr = p2_chunk_ff;
      end else begin
         mc = st_a_ext;
         mr = st_wide_ff ? {1'b0, st_b_ff[15:0]} : {st_sgn_ff & st_b_ff[15], st_b_ff[15:0]};
      end
   end

   mdu_booth_pass u_pass (
      .multiplicand (mc),
      .multiplier   (mr),
      .product      (pass_prod)
   );

   wire        done_valid = p2_valid_ff | (st_valid_ff & ~st_wide_ff);
   wire [2:0]  done_op    = p2_valid_ff ? p2_op_ff : st_op_ff;
   wire [4:0]  done_dest  = p2_valid_ff ? p2_dest_ff : st_dest_ff;
   wire [63:0] done_prod  = p2_valid_ff ? (p2_low_ff + {pass_ext[47:0], 16'h0}) : pass_ext;

   // ************************************************************
   // result pair update
   // ************************************************************
   reg [63:0] base;
   reg [63:0] nxt_pair;

   always @* begin
      base     = div_wb_ff ? {dvr_hi_ff, dvr_lo_ff} : {upper_result_reg_ff, bottom_result_reg_ff};
      nxt_pair = base;
      if (done_valid) begin
         case (done_op)
            `MDU_OP_PAIR_PRODUCT: nxt_pair = done_prod;
            `MDU_OP_ACCUM_ADD:    nxt_pair = base + done_prod;
            `MDU_OP_ACCUM_SUB:    nxt_pair = base - done_prod;
            default:              nxt_pair = base;
         endcase
      end
   end

   // ************************************************************
   // divide setup: magnitude and early-in width check
   // ************************************************************
   wire        dl_neg = ISSUE_SIGNED & LEFT_OPERAND[31];
   wire        dr_neg = ISSUE_SIGNED & RIGHT_OPERAND[31];
   wire [31:0] dl_mag = dl_neg ? (32'h0 - LEFT_OPERAND) : LEFT_OPERAND;
   wire [31:0] dr_mag = dr_neg ? (32'h0 - RIGHT_OPERAND) : RIGHT_OPERAND;
   wire fits8  = ISSUE_SIGNED ? ((&LEFT_OPERAND[31:7]) | ~(|LEFT_OPERAND[31:7])) : ~(|LEFT_OPERAND[31:8]);
   wire fits16 = ISSUE_SIGNED ? ((&LEFT_OPERAND[31:15]) | ~(|LEFT_OPERAND[31:15])) : ~(|LEFT_OPERAND[31:16]);
   wire fits24 = ISSUE_SIGNED ? ((&LEFT_OPERAND[31:23]) | ~(|LEFT_OPERAND[31:23])) : ~(|LEFT_OPERAND[31:24]);
   reg  [4:0]  ld_skip;
   reg  [5:0]  ld_lat;
   wire [5:0]  ld_iter = `MDU_DIV_FULL_ITER - {1'b0, ld_skip};

   always @* begin
      if (fits8) begin
         ld_skip = `MDU_DIV_SKIP_8;
         ld_lat  = `MDU_DIV_LAT_8;
      end else if (fits16) begin
         ld_skip = `MDU_DIV_SKIP_16;
         ld_lat  = `MDU_DIV_LAT_16;
      end else if (fits24) begin
         ld_skip = `MDU_DIV_SKIP_24;
         ld_lat  = `MDU_DIV_LAT_24;
      end else begin
         ld_skip = `MDU_DIV_SKIP_32;
         ld_lat  = `MDU_DIV_LAT_32;
      end
   end

   // ************************************************************
   // divide state machine
   // ************************************************************
   wire [32:0] trial  = {dv_rem_ff, dv_q_ff[31]} - {1'b0, dv_d_ff};
   wire [31:0] it_rem = trial[32] ? {dv_rem_ff[30:0], dv_q_ff[31]} : trial[31:0];
   wire [31:0] it_q   = {dv_q_ff[30:0], ~trial[32]};
   reg  [1:0]  nxt_state;
   reg  [5:0]  nxt_cnt;
   reg  [5:0]  nxt_iter;
   reg  [31:0] nxt_rem;
   reg  [31:0] nxt_q;
   reg  [31:0] nxt_d;
   reg         nxt_negq;
   reg         nxt_negr;
   reg  [31:0] nxt_hi;
   reg  [31:0] nxt_lo;
   reg         nxt_wb;
   wire [5:0]  ld_cnt = ld_lat - 6'h01;

   always @* begin
      nxt_state = dv_state_ff;
      nxt_cnt   = dv_cnt_ff;
      nxt_iter  = dv_iter_ff;
      nxt_rem   = dv_rem_ff;
      nxt_q     = dv_q_ff;
      nxt_d     = dv_d_ff;
      nxt_negq  = dv_negq_ff;
      nxt_negr  = dv_negr_ff;
      nxt_hi    = dvr_hi_ff;
      nxt_lo    = dvr_lo_ff;
      nxt_wb    = 1'b0;
      case (dv_state_ff)
         `MDU_DV_SETUP: begin
            nxt_cnt = dv_cnt_ff - 6'h01;
            if (nxt_cnt == dv_iter_ff) begin
               nxt_state = `MDU_DV_ITER;
            end
         end
         `MDU_DV_ITER: begin
            nxt_rem = it_rem;
            nxt_q   = it_q;
            nxt_cnt = dv_cnt_ff - 6'h01;
            if (dv_cnt_ff == 6'h01) begin
               nxt_state = `MDU_DV_IDLE;
               nxt_lo    = dv_negq_ff ? (32'h0 - it_q) : it_q;
               nxt_hi    = dv_negr_ff ? (32'h0 - it_rem) : it_rem;
               nxt_wb    = 1'b1;
            end
         end
         default: nxt_state = `MDU_DV_IDLE;
      endcase
      if (take_div) begin
         nxt_state = (ld_cnt > ld_iter) ? `MDU_DV_SETUP : `MDU_DV_ITER;
         nxt_cnt   = ld_cnt;
         nxt_iter  = ld_iter;
         nxt_rem   = `MDU_RST_WORD;
         nxt_q     = dl_mag << ld_skip;
         nxt_d     = dr_mag;
         nxt_negq  = dl_neg ^ dr_neg;
         nxt_negr  = dl_neg;
      end
   end

   // stall: second pass of a full multiply, or divide not yet at its repeat point
   wire nxt_stall = (take_mul & r_wide) | ((nxt_state != `MDU_DV_IDLE) & (nxt_cnt >= 6'h02));

   // ************************************************************
   // registers; nothing here waits on the integer pipeline
   // ************************************************************
   always @(posedge CLOCK) begin
      if (SRST) begin
         stall_ff             <= 1'b0;
         st_valid_ff          <= 1'b0;
         st_op_ff             <= `MDU_OP_PAIR_PRODUCT;
         st_sgn_ff            <= 1'b0;
         st_wide_ff           <= 1'b0;
         st_a_ff              <= `MDU_RST_WORD;
         st_b_ff              <= `MDU_RST_WORD;
         st_dest_ff           <= `MDU_RST_DEST;
         p2_valid_ff          <= 1'b0;
         p2_op_ff             <= `MDU_OP_PAIR_PRODUCT;
         p2_dest_ff           <= `MDU_RST_DEST;
         p2_a_ff              <= 33'h0;
         p2_chunk_ff          <= 17'h0;
         p2_low_ff            <= 64'h0;
         upper_result_reg_ff  <= `MDU_RST_WORD;
         bottom_result_reg_ff <= `MDU_RST_WORD;
         dv_state_ff          <= `MDU_DV_IDLE;
         dv_cnt_ff            <= 6'h0;
         dv_iter_ff           <= 6'h0;
         dv_rem_ff            <= `MDU_RST_WORD;
         dv_q_ff              <= `MDU_RST_WORD;
         dv_d_ff              <= `MDU_RST_WORD;
         dv_negq_ff           <= 1'b0;
         dv_negr_ff           <= 1'b0;
         dvr_hi_ff            <= `MDU_RST_WORD;
         dvr_lo_ff            <= `MDU_RST_WORD;
         div_wb_ff            <= 1'b0;
         gpr_pend_ff          <= 1'b0;
         gpr_pdest_ff         <= `MDU_RST_DEST;
         gpr_pdata_ff         <= `MDU_RST_WORD;
         gpr_valid_ff         <= 1'b0;
         gpr_dest_ff          <= `MDU_RST_DEST;
         gpr_data_ff          <= `MDU_RST_WORD;
         mv_pend_ff           <= 1'b0;
         mv_sel_ff            <= 1'b0;
         move_valid_ff        <= 1'b0;
         move_data_ff         <= `MDU_RST_WORD;
      end else begin
         stall_ff    <= nxt_stall;
         // operand stage, first pass
         st_valid_ff <= take_mul;
         if (take_mul) begin
            st_op_ff   <= ISSUE_OP;
            st_sgn_ff  <= ISSUE_SIGNED;
            st_wide_ff <= r_wide;
            st_a_ff    <= LEFT_OPERAND;
            st_b_ff    <= RIGHT_OPERAND;
            st_dest_ff <= ISSUE_DEST;
         end
         // second pass of a full-width multiply
         p2_valid_ff <= st_valid_ff & st_wide_ff;
         if (st_valid_ff & st_wide_ff) begin
            p2_op_ff    <= st_op_ff;
            p2_dest_ff  <= st_dest_ff;
            p2_a_ff     <= st_a_ext;
            p2_chunk_ff <= {st_sgn_ff & st_b_ff[31], st_b_ff[31:16]};
            p2_low_ff   <= pass_ext;
         end
         upper_result_reg_ff  <= nxt_pair[63:32];
         bottom_result_reg_ff <= nxt_pair[31:0];
         // divider
         dv_state_ff <= nxt_state;
         dv_cnt_ff   <= nxt_cnt;
         dv_iter_ff  <= nxt_iter;
         dv_rem_ff   <= nxt_rem;
         dv_q_ff     <= nxt_q;
         dv_d_ff     <= nxt_d;
         dv_negq_ff  <= nxt_negq;
         dv_negr_ff  <= nxt_negr;
         dvr_hi_ff   <= nxt_hi;
         dvr_lo_ff   <= nxt_lo;
         div_wb_ff   <= nxt_wb;
         // register-file multiply: one extra stage
         gpr_pend_ff <= done_valid & (done_op == `MDU_OP_GPR_PRODUCT);
         if (done_valid & (done_op == `MDU_OP_GPR_PRODUCT)) begin
            gpr_pdest_ff <= done_dest;
            gpr_pdata_ff <= done_prod[31:0];
         end
         gpr_valid_ff <= gpr_pend_ff;
         gpr_dest_ff  <= gpr_pdest_ff;
         gpr_data_ff  <= gpr_pdata_ff;
         // move out of the pair, sees any result landing that edge
         mv_pend_ff    <= take_mv;
         if (take_mv) begin
            mv_sel_ff <= (ISSUE_OP == `MDU_OP_MOVE_UPPER);
         end
         move_valid_ff <= mv_pend_ff;
         if (mv_pend_ff) begin
            move_data_ff <= mv_sel_ff ? nxt_pair[63:32] : nxt_pair[31:0];
         end
      end
   end

endmodule

// ===== testbench/mdu_chk.sv
// checker of the multiply/divide unit port timing
`timescale 1ns/1ns
module mdu_chk (
   input wire        CLOCK,
   input wire        SRST,
   input wire        ISSUE_VALID,
   input wire [2:0]  ISSUE_OP,
   input wire        ISSUE_SIGNED,
   input wire [4:0]  ISSUE_DEST,
   input wire [31:0] LEFT_OPERAND,
   input wire [31:0] RIGHT_OPERAND,
   input wire        STALL,
   input wire        MOVE_VALID,
   input wire [31:0] MOVE_DATA,
   input wire        GPR_WRITE_VALID,
   input wire [4:0]  GPR_WRITE_DEST,
   input wire [31:0] GPR_WRITE_DATA
);
   // ************************************************************
   // helper logic
   // ************************************************************
   function [5:0] dlat(input [31:0] a, input sg);
      if (sg ? (&a[31:7] || ~|a[31:7]) : ~|a[31:8]) dlat = 6'h0c;
      else if (sg ? (&a[31:15] || ~|a[31:15]) : ~|a[31:16]) dlat = 6'h13;
      else if (sg ? (&a[31:23] || ~|a[31:23]) : ~|a[31:24]) dlat = 6'h1a;
      else dlat = 6'h21;
   endfunction
   wire        take  = ISSUE_VALID && !STALL;
   wire        mul   = ISSUE_OP <= 3'h3;
   wire        mv    = ISSUE_OP == 3'h5 || ISSUE_OP == 3'h6;
   wire        gpr   = take && ISSUE_OP == 3'h3;
   wire        shrt  = ISSUE_SIGNED ? (&RIGHT_OPERAND[31:15] || ~|RIGHT_OPERAND[31:15]) : ~|RIGHT_OPERAND[31:16];
   wire [63:0] prod  = ISSUE_SIGNED ? $signed({{32{LEFT_OPERAND[31]}}, LEFT_OPERAND}) *
                       $signed({{32{RIGHT_OPERAND[31]}}, RIGHT_OPERAND}) : {32'h0, LEFT_OPERAND} * {32'h0, RIGHT_OPERAND};
   wire [31:0] prod_lo = prod[31:0];
   reg  [5:0]  run_ff;
   reg  [5:0]  exp_ff;
   always @(posedge CLOCK) begin
      if (SRST) begin
         run_ff <= 6'h00;
         exp_ff <= 6'h00;
      end else begin
         run_ff <= STALL ? run_ff + 6'h01 : 6'h00;
         if (take) begin
            exp_ff <= (ISSUE_OP == 3'h4) ? dlat(LEFT_OPERAND, ISSUE_SIGNED) - 6'h02 : 6'h01;
         end
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);
   // ************************************************************
   // assertions
   // ************************************************************
   short_mul_a: assert property (take && mul && shrt |=> !STALL)
      else $error("short multiply stalled");
   wide_mul_a: assert property (take && mul && !shrt |=> STALL ##1 !STALL)
      else $error("wide multiply stall not one cycle");
   div_stall_a: assert property (take && ISSUE_OP == 3'h4 |=> STALL)
      else $error("divide did not stall issue");
   stall_len_a: assert property ($fell(STALL) |-> run_ff == exp_ff)
      else $error("stall length wrong");
   stall_cause_a: assert property ($rose(STALL) |-> $past(take && (ISSUE_OP == 3'h4 || (mul && !shrt))))
      else $error("stall without cause");
   gpr_short_a: assert property (gpr && shrt |-> ##3 GPR_WRITE_VALID && GPR_WRITE_DEST == $past(ISSUE_DEST, 3)
      && GPR_WRITE_DATA == $past(prod_lo, 3))
      else $error("short register product wrong");
   gpr_wide_a: assert property (gpr && !shrt |-> ##4 GPR_WRITE_VALID && GPR_WRITE_DEST == $past(ISSUE_DEST, 4)
      && GPR_WRITE_DATA == $past(prod_lo, 4))
      else $error("wide register product wrong");
   gpr_cause_a: assert property (GPR_WRITE_VALID |-> $past(gpr && shrt, 3) || $past(gpr && !shrt, 4))
      else $error("register write without product");
   move_pulse_a: assert property (take && mv |-> ##2 MOVE_VALID)
      else $error("move result missing");
   move_cause_a: assert property (MOVE_VALID |-> $past(take && mv, 2))
      else $error("move result without move");
endmodule
bind mdu_multiply_divide_unit mdu_chk u_chk (.CLOCK(CLOCK), .SRST(SRST), .ISSUE_VALID(ISSUE_VALID),
   .ISSUE_OP(ISSUE_OP), .ISSUE_SIGNED(ISSUE_SIGNED), .ISSUE_DEST(ISSUE_DEST), .LEFT_OPERAND(LEFT_OPERAND),
   .RIGHT_OPERAND(RIGHT_OPERAND), .STALL(STALL), .MOVE_VALID(MOVE_VALID), .MOVE_DATA(MOVE_DATA),
   .GPR_WRITE_VALID(GPR_WRITE_VALID), .GPR_WRITE_DEST(GPR_WRITE_DEST), .GPR_WRITE_DATA(GPR_WRITE_DATA));

// ===== testbench/mdu_ipipe_model.sv
// integer pipeline model issuing requests to the unit
`timescale 1ns/1ns
module mdu_ipipe_model (
   input  wire        CLOCK,
   input  wire        STALL,
   output reg         ISSUE_VALID,
   output reg  [2:0]  ISSUE_OP,
   output reg         ISSUE_SIGNED,
   output reg  [4:0]  ISSUE_DEST,
   output reg  [31:0] LEFT_OPERAND,
   output reg  [31:0] RIGHT_OPERAND
);
   time    t_take;
   integer hang;
   initial begin
      {ISSUE_VALID, ISSUE_OP, ISSUE_SIGNED, ISSUE_DEST, LEFT_OPERAND, RIGHT_OPERAND} = 74'h0;
      t_take = 0;
      hang = 0;
   end
   // hold one request until an edge without stall
   task send(input [2:0] op, input sg, input [4:0] dst, input [31:0] a, input [31:0] b);
      integer n;
      begin
         @(negedge CLOCK);
         {ISSUE_VALID, ISSUE_OP, ISSUE_SIGNED, ISSUE_DEST, LEFT_OPERAND, RIGHT_OPERAND} = {1'b1, op, sg, dst, a, b};
         n = 0;
         while (STALL && n < 60) begin
            @(negedge CLOCK);
            n = n + 1;
         end
         @(posedge CLOCK);
         t_take = $time;
         if (n == 60) hang = 1;
      end
   endtask
   // no request: operands turn to garbage
   task idle;
      begin
         @(negedge CLOCK);
         ISSUE_VALID = 1'b0;
         {ISSUE_OP, ISSUE_SIGNED, ISSUE_DEST, LEFT_OPERAND, RIGHT_OPERAND} =
            ~{ISSUE_OP, ISSUE_SIGNED, ISSUE_DEST, LEFT_OPERAND, RIGHT_OPERAND};
      end
   endtask
endmodule

// ===== testbench/tb.sv
// self-checking testbench of the multiply/divide unit
`timescale 1ns/1ns
`include "mdu_defs.vh"
module tb;
   reg          clock;
   reg          srst;
   wire         stall, mv_v, gw_v, iv, isg;
   wire [2:0]   iop;
   wire [4:0]   idst, gw_a;
   wire [31:0]  ia, ib, mv_d, gw_d;
   integer      mismatches, n_checks, k;
   reg  [31:0]  hi, lo, a, b;
   reg  [36:0]  mv_q[$];
   reg  [36:0]  gw_q[$];
   reg  [36:0]  gw_e[$];
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   mdu_ipipe_model u_ip (.CLOCK(clock), .STALL(stall), .ISSUE_VALID(iv), .ISSUE_OP(iop), .ISSUE_SIGNED(isg),
      .ISSUE_DEST(idst), .LEFT_OPERAND(ia), .RIGHT_OPERAND(ib));
   mdu_multiply_divide_unit u_dut (.CLOCK(clock), .SRST(srst), .ISSUE_VALID(iv), .ISSUE_OP(iop),
      .ISSUE_SIGNED(isg), .ISSUE_DEST(idst), .LEFT_OPERAND(ia), .RIGHT_OPERAND(ib), .STALL(stall),
      .MOVE_VALID(mv_v), .MOVE_DATA(mv_d), .GPR_WRITE_VALID(gw_v), .GPR_WRITE_DEST(gw_a), .GPR_WRITE_DATA(gw_d));
   always @(negedge clock) begin
      if (mv_v === 1'b1) mv_q.push_back({5'h00, mv_d});
      if (gw_v === 1'b1) gw_q.push_back({gw_a, gw_d});
   end
   // ************************************************************
   // reference model and compares
   // ************************************************************
   function integer dl(input [31:0] x, input sg);
      if (sg ? (&x[31:7] || ~|x[31:7]) : ~|x[31:8]) dl = 12;
      else if (sg ? (&x[31:15] || ~|x[31:15]) : ~|x[31:16]) dl = 19;
      else if (sg ? (&x[31:23] || ~|x[31:23]) : ~|x[31:24]) dl = 26;
      else dl = 33;
   endfunction
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task fail(input integer c);
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0t no answer, case %0d", $time, c);
         stop_test;
      end
   endtask
   task chk_d(input [36:0] e, input [36:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t result exp %h got %h", $time, e, g);
         end
      end
   endtask
   task chk_t(input integer e, input integer g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t repeat exp %0d got %0d", $time, e, g);
         end
      end
   endtask
   task iss(input [2:0] op, input sg, input [31:0] x, input [31:0] y);
      begin
         u_ip.send(op, sg, x[4:0], x, y);
         if (u_ip.hang != 0) fail(1);
      end
   endtask
   // one operation, then both halves moved out back to back
   task do_op(input [2:0] op, input sg, input [31:0] x, input [31:0] y);
      reg [63:0] p;
      integer    rep, n;
      time       t0;
      begin
         p = sg ? $signed({{32{x[31]}}, x}) * $signed({{32{y[31]}}, y}) : {32'h0, x} * {32'h0, y};
         rep = (sg ? (&y[31:15] || ~|y[31:15]) : ~|y[31:16]) ? 1 : 2;
         case (op)
            `MDU_OP_PAIR_PRODUCT: {hi, lo} = p;
            `MDU_OP_ACCUM_ADD: {hi, lo} = {hi, lo} + p;
            `MDU_OP_ACCUM_SUB: {hi, lo} = {hi, lo} - p;
            `MDU_OP_GPR_PRODUCT: gw_e.push_back({x[4:0], p[31:0]});
            default: begin
               rep = dl(x, sg) - 1;
               if (sg) begin
                  lo = $signed(x) / $signed(y);
                  hi = $signed(x) % $signed(y);
               end else begin
                  lo = x / y;
                  hi = x % y;
               end
            end
         endcase
         iss(op, sg, x, y);
         t0 = u_ip.t_take;
         iss(`MDU_OP_MOVE_UPPER, 1'b0, 32'h0, 32'h0);
         chk_t(rep, (u_ip.t_take - t0) / 10);
         iss(`MDU_OP_MOVE_BOTTOM, 1'b0, 32'h0, 32'h0);
         u_ip.idle;
         n = 0;
         while ((mv_q.size() < 2 || gw_q.size() < gw_e.size()) && n < 80) begin
            @(negedge clock);
            n = n + 1;
         end
         if (n == 80) fail(2);
         chk_d({5'h00, hi}, mv_q.pop_front());
         chk_d({5'h00, lo}, mv_q.pop_front());
         if (gw_e.size() > 0) chk_d(gw_e.pop_front(), gw_q.pop_front());
      end
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      srst = 1'b1;
      mismatches = 0;
      n_checks = 0;
      {hi, lo} = 64'h0;
      k = $urandom(32'h44cb);
      repeat (10) @(negedge clock);
      srst = 1'b0;
      do_op(3'h0, 1'b1, 32'h8000_0001, 32'hffff_8000);
      do_op(3'h0, 1'b0, 32'hffff_ffff, 32'h0001_0000);
      do_op(3'h1, 1'b1, 32'h1234_5678, 32'h8000_0000);
      do_op(3'h2, 1'b0, 32'hdead_beef, 32'h0000_ffff);
      do_op(3'h3, 1'b1, 32'hffff_fff3, 32'h0000_7fff);
      do_op(3'h3, 1'b0, 32'h7654_3210, 32'hfedc_ba98);
      do_op(3'h4, 1'b1, 32'hffff_ff85, 32'h0000_0007);
      do_op(3'h4, 1'b0, 32'h0000_fedc, 32'h0000_0013);
      do_op(3'h4, 1'b1, 32'h0040_0000, 32'hffff_fffd);
      do_op(3'h4, 1'b0, 32'hfedc_ba98, 32'h0000_0321);
      do_op(3'h4, 1'b1, 32'h8000_0000, 32'h0000_0003);
      $display("test directed done");
      for (k = 0; k < 40; k = k + 1) begin
         a = $urandom >> (8 * ($urandom % 4));
         b = $urandom;
         if (k[0]) b = {{16{b[15]}}, b[15:0]};
         if (k[1]) a = ~a;
         if (b == 32'h0 || (a == 32'h8000_0000 && &b)) b = 32'h5;
         do_op(3'($urandom % 5), 1'($urandom % 2), a, b);
      end
      $display("test random done");
      stop_test;
   end
endmodule
